// file: shared/dsc_pkg.sv
// dsc_pkg: offsets, field positions, reset values and enumerations of the
// distributed dma slave channel register slice.
// assumes byte offsets relative to the dma base of the i/o window.
package dsc_pkg;

  // byte offsets within the 16-byte window
  localparam logic [3:0] OFS_ADDRESS_PAGE   = 4'h2;
  localparam logic [3:0] OFS_COUNT_LO       = 4'h4;
  localparam logic [3:0] OFS_COUNT_HI       = 4'h5;
  localparam logic [3:0] OFS_CMD_STATUS     = 4'h8;

  // reset values
  localparam logic [7:0]  RST_ADDRESS_PAGE  = 8'h00;
  localparam logic [15:0] RST_TRANSFER_CNT  = 16'h0000;
  localparam logic        RST_CTRL_DISABLE  = 1'b0;
  localparam logic        RST_TC_FLAG       = 1'b0;

  // field positions
  localparam int CMD_DISABLE_BIT  = 2;
  localparam int STAT_REQ_LSB     = 4;
  localparam int STAT_TC_LSB      = 0;
  localparam int STAT_GROUP_WIDTH = 4;

  // count decrement per completed transfer
  localparam logic [15:0] STEP_8BIT  = 16'h0001;
  localparam logic [15:0] STEP_16BIT = 16'h0002;

  typedef enum logic {
    DSC_MODE_8BIT,
    DSC_MODE_16BIT
  } dsc_width_t;

endpackage : dsc_pkg

// file: shared/dsc_count_if.sv
// dsc_count_if: link between the register front end and the count unit.
// assumes both ends share ref_clk and rst_n.
`timescale 1ns/10ps
interface dsc_count_if;
  logic                 load_lo;
  logic                 load_hi;
  logic [7:0]           load_data;
  logic                 xfer_step;
  dsc_pkg::dsc_width_t  width_mode;
  logic [15:0]          count;
  logic                 tc_hit;

  modport front
  (
    output load_lo,
    output load_hi,
    output load_data,
    output xfer_step,
    output width_mode,
    input  count,
    input  tc_hit
  );

  modport unit
  (
    input  load_lo,
    input  load_hi,
    input  load_data,
    input  xfer_step,
    input  width_mode,
    output count,
    output tc_hit
  );
endinterface : dsc_count_if

// file: design/dsc_count_unit.sv
// dsc_count_unit: remaining byte count of the channel and terminal count detect.
// assumes load and step strobes are one-cycle pulses from the front end.
`timescale 1ns/10ps
module dsc_count_unit
(
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  input  wire logic  chan_clear,
  dsc_count_if.unit  cnt
);

  logic [15:0] step;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic        tc_r;
  logic        last_step;

  assign step = (cnt.width_mode == dsc_pkg::DSC_MODE_16BIT) ? dsc_pkg::STEP_16BIT
                                                            : dsc_pkg::STEP_8BIT;
  // a transfer that consumes the last bytes ends the block
  assign last_step = (count_r <= step);

  always_comb
  begin
    count_nxt = count_r;
    if (cnt.xfer_step)
    begin
      // saturate at zero so a stray transfer cannot wrap to a huge count
      count_nxt = last_step ? 16'h0000 : count_r - step;
    end
    if (cnt.load_lo)
    begin
      count_nxt[7:0] = cnt.load_data;
    end
    if (cnt.load_hi)
    begin
      count_nxt[15:8] = cnt.load_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r <= dsc_pkg::RST_TRANSFER_CNT;
    end
    else if (chan_clear)
    begin
      count_r <= dsc_pkg::RST_TRANSFER_CNT;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tc_r <= 1'b0;
    end
    else
    begin
      tc_r <= cnt.xfer_step && last_step && !chan_clear;
    end
  end

  assign cnt.count  = count_r;
  assign cnt.tc_hit = tc_r;

endmodule : dsc_count_unit

// file: design/dsc_channel_regs.sv
// dsc_channel_regs: page, count, command and status registers of one
// distributed dma slave channel serving a single card socket.
// assumes byte-wide i/o accesses already decoded to the channel's window,
// one-cycle read and write strobes synchronous to ref_clk.
`timescale 1ns/10ps
module dsc_channel_regs
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register access over the i/o window
  input  wire logic [3:0]  io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rvalid,
  // channel side
  input  wire logic        card_dma_request,
  input  wire logic        xfer_16bit,
  input  wire logic        xfer_done,
  input  wire logic        channel_reset,
  input  wire logic        addr_phase,
  output logic      [7:0]  ad_hi_out,
  output logic      [7:0]  ad_hi_oe,
  output logic             ctrl_disabled,
  output logic             request_status,
  output logic             terminal_count,
  output logic      [15:0] count_remaining
);

  logic [7:0]  address_page_r;
  logic        ctrl_disable_r;
  logic        tc_flag_r;
  logic        req_sync_r;
  logic [7:0]  io_rdata_r;
  logic        io_rvalid_r;
  logic [7:0]  ad_hi_r;
  logic [7:0]  ad_hi_oe_r;
  logic [7:0]  status_view;
  logic [7:0]  rd_mux;
  logic        wr_page;
  logic        wr_cmd;
  logic        rd_status;
  logic        tc_set;

  dsc_count_if cnt ();

  // write and status read decode
  assign wr_page   = io_wr && (io_addr == dsc_pkg::OFS_ADDRESS_PAGE);
  assign wr_cmd    = io_wr && (io_addr == dsc_pkg::OFS_CMD_STATUS);
  assign rd_status = io_rd && (io_addr == dsc_pkg::OFS_CMD_STATUS);

  assign cnt.load_lo    = io_wr && (io_addr == dsc_pkg::OFS_COUNT_LO);
  assign cnt.load_hi    = io_wr && (io_addr == dsc_pkg::OFS_COUNT_HI);
  assign cnt.load_data  = io_wdata;
  // a disabled controller completes no transfers, so the count holds
  assign cnt.xfer_step  = xfer_done && !ctrl_disable_r;
  assign cnt.width_mode = xfer_16bit ? dsc_pkg::DSC_MODE_16BIT : dsc_pkg::DSC_MODE_8BIT;

  dsc_count_unit u_count
  (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .chan_clear (channel_reset),
    .cnt        (cnt)
  );

  // page register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      address_page_r <= dsc_pkg::RST_ADDRESS_PAGE;
    end
    else if (channel_reset)
    begin
      address_page_r <= dsc_pkg::RST_ADDRESS_PAGE;
    end
    else if (wr_page)
    begin
      address_page_r <= io_wdata;
    end
  end

  // command register: only the disable bit is stored
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_disable_r <= dsc_pkg::RST_CTRL_DISABLE;
    end
    else if (channel_reset)
    begin
      ctrl_disable_r <= dsc_pkg::RST_CTRL_DISABLE;
    end
    else if (wr_cmd)
    begin
      ctrl_disable_r <= io_wdata[dsc_pkg::CMD_DISABLE_BIT];
    end
  end

  // request input registered once; treated as synchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_sync_r <= 1'b0;
    end
    else
    begin
      req_sync_r <= card_dma_request;
    end
  end

  // sticky terminal count; a new hit in the clearing cycle is kept
  assign tc_set = cnt.tc_hit;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tc_flag_r <= dsc_pkg::RST_TC_FLAG;
    end
    else if (tc_set)
    begin
      tc_flag_r <= 1'b1;
    end
    else if (rd_status || channel_reset)
    begin
      tc_flag_r <= 1'b0;
    end
  end

  // status image
  always_comb
  begin
    status_view = 8'h00;
    status_view[dsc_pkg::STAT_REQ_LSB +: dsc_pkg::STAT_GROUP_WIDTH] =
      {dsc_pkg::STAT_GROUP_WIDTH{req_sync_r}};
    status_view[dsc_pkg::STAT_TC_LSB +: dsc_pkg::STAT_GROUP_WIDTH] =
      {dsc_pkg::STAT_GROUP_WIDTH{tc_flag_r}};
  end

  // read mux; the command image is not readable at the shared offset
  always_comb
  begin
    unique case (io_addr)
      dsc_pkg::OFS_ADDRESS_PAGE: rd_mux = address_page_r;
      dsc_pkg::OFS_COUNT_LO:     rd_mux = cnt.count[7:0];
      dsc_pkg::OFS_COUNT_HI:     rd_mux = cnt.count[15:8];
      dsc_pkg::OFS_CMD_STATUS:   rd_mux = status_view;
      default:                   rd_mux = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_rdata_r <= 8'h00;
    end
    else if (io_rd)
    begin
      io_rdata_r <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_rvalid_r <= 1'b0;
    end
    else
    begin
      io_rvalid_r <= io_rd;
    end
  end

  // address phase image of the page; bit 0 is left undriven in 16-bit
  // mode because the address register owns that line there
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ad_hi_r    <= 8'h00;
      ad_hi_oe_r <= 8'h00;
    end
    else if (addr_phase && !ctrl_disable_r)
    begin
      ad_hi_r    <= xfer_16bit ? {address_page_r[7:1], 1'b0} : address_page_r;
      ad_hi_oe_r <= xfer_16bit ? 8'hfe : 8'hff;
    end
    else
    begin
      ad_hi_r    <= 8'h00;
      ad_hi_oe_r <= 8'h00;
    end
  end

  assign io_rdata        = io_rdata_r;
  assign io_rvalid       = io_rvalid_r;
  assign ad_hi_out       = ad_hi_r;
  assign ad_hi_oe        = ad_hi_oe_r;
  assign ctrl_disabled   = ctrl_disable_r;
  assign request_status  = req_sync_r;
  assign terminal_count  = tc_flag_r;
  assign count_remaining = cnt.count;

endmodule : dsc_channel_regs

// file: tb/dsc_channel_regs_props.sv
// dsc_channel_regs_props: port-level checks of the channel register slice.
// assumes a bind onto dsc_channel_regs, one clock, rst_n active low.
`timescale 1ns/10ps
module dsc_channel_regs_props
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid,
  input wire logic        card_dma_request,
  input wire logic        xfer_16bit,
  input wire logic        xfer_done,
  input wire logic        channel_reset,
  input wire logic        addr_phase,
  input wire logic [7:0]  ad_hi_out,
  input wire logic [7:0]  ad_hi_oe,
  input wire logic        ctrl_disabled,
  input wire logic        request_status,
  input wire logic        terminal_count,
  input wire logic [15:0] count_remaining
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_stat_rd;
    io_rd && io_addr == 4'h8;
  endsequence
  // writes and channel reset may also move the count, so they are left out
  sequence s_step;
    xfer_done && !ctrl_disabled && !io_wr && !channel_reset;
  endsequence
  a_status_read:
  assert property (s_stat_rd |=> io_rvalid && io_rdata == {{4{$past(request_status)}}, {4{$past(terminal_count)}}})
    else $error("status read value wrong");
  a_req_follow:
  assert property (1'b1 |=> request_status == $past(card_dma_request)) else $error("request status lags");
  a_tc_clear:
  assert property (s_stat_rd ##0 !xfer_done && !$past(xfer_done) |=> !terminal_count) else $error("tc not cleared");
  a_step_8bit:
  assert property (s_step ##0 !xfer_16bit && count_remaining != 16'h0000
    |=> count_remaining == $past(count_remaining) - 16'h0001) else $error("8-bit step wrong");
  a_step_16bit:
  assert property (s_step ##0 xfer_16bit && count_remaining > 16'h0001
    |=> count_remaining == $past(count_remaining) - 16'h0002) else $error("16-bit step wrong");
  a_tc_set:
  assert property (s_step ##0 count_remaining <= (xfer_16bit ? 16'h0002 : 16'h0001) |-> ##2 terminal_count)
    else $error("tc not set");
  a_cmd_write:
  assert property (io_wr && io_addr == 4'h8 && !channel_reset |=> ctrl_disabled == $past(io_wdata[2]))
    else $error("command bit wrong");
  a_lane_drive:
  assert property (addr_phase && !ctrl_disabled && !io_wr && !channel_reset
    |=> ad_hi_oe == ($past(xfer_16bit) ? 8'hfe : 8'hff) && (ad_hi_out & ~ad_hi_oe) == 8'h00)
    else $error("address lanes wrong");
endmodule : dsc_channel_regs_props

// file: tb/dsc_master_model.sv
// dsc_master_model: far-side master running a burst of transfers.
// assumes go is raised on a rising edge and held until busy falls.
`timescale 1ns/10ps
module dsc_master_model
(
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [7:0] beats,
  output logic            xfer_done,
  output logic            addr_phase,
  output logic            busy
);
  logic [7:0] left_r = 8'h00;
  logic [1:0] ph_r = 2'h0;
  logic       armed_r = 1'b0;
  assign busy = left_r != 8'h00;
  initial {xfer_done, addr_phase} = 2'b00;
  // slow mode stretches the wait between address phase and completion
  always @(negedge ref_clk)
  begin
    addr_phase <= 1'b0;
    xfer_done <= 1'b0;
    if (busy)
    begin
      if (ph_r == 2'h0)
      begin
        addr_phase <= 1'b1;
        ph_r <= slow ? 2'h3 : 2'h1;
      end
      else if (ph_r == 2'h1)
      begin
        xfer_done <= 1'b1;
        left_r <= left_r - 8'h01;
        ph_r <= 2'h0;
      end
      else
        ph_r <= ph_r - 2'h1;
    end
    else if (go && !armed_r)
    begin
      left_r <= beats;
      armed_r <= 1'b1;
    end
    if (!go)
      armed_r <= 1'b0;
  end
endmodule : dsc_master_model

// file: tb/dsc_channel_regs_tb.sv
// dsc_channel_regs_tb: register and transfer tests of the channel slice.
// assumes dsc_master_model as far-side master, ref_clk at 100 MHz.
`timescale 1ns/10ps
module dsc_channel_regs_tb;
  logic ref_clk, rst_n, io_wr, io_rd, card_dma_request, xfer_16bit, channel_reset, go, slow;
  logic io_rvalid, xfer_done, addr_phase, ctrl_disabled, request_status, terminal_count, busy;
  logic [3:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata, ad_hi_out, ad_hi_oe, beats;
  logic [15:0] count_remaining;
  int          err_count = 0;
  int          checked = 0;
  dsc_channel_regs dut_u (.ref_clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rvalid,
    .card_dma_request, .xfer_16bit, .xfer_done, .channel_reset, .addr_phase, .ad_hi_out, .ad_hi_oe,
    .ctrl_disabled, .request_status, .terminal_count, .count_remaining);
  dsc_master_model mst_u (.ref_clk, .go, .slow, .beats, .xfer_done, .addr_phase, .busy);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
    @(negedge ref_clk);
    io_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    {io_addr, io_rd} = {a, 1'b1};
    @(negedge ref_clk);
    io_rd = 1'b0;
    chk({7'h00, io_rvalid, io_rdata}, {8'h01, exp});
  endtask : rd
  // the two idle cycles at the end let a late terminal count land before any read
  task automatic xf(input logic [7:0] n, input logic s);
    int k;
    @(posedge ref_clk);
    {beats, slow, go} <= {n, s, 1'b1};
    repeat (3) @(posedge ref_clk);
    for (k = 0; k < 100 && busy === 1'b1; k++) @(posedge ref_clk);
    go <= 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : xf
  task automatic stop_test;
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // page image on the upper address lanes whenever they are driven; bit 0 drops out in 16-bit mode
  always @(negedge ref_clk)
  begin
    if (ad_hi_oe !== 8'h00)
      chk({8'h00, ad_hi_out}, {8'h00, (xfer_16bit ? 8'ha4 : 8'ha5)});
  end
  initial
  begin
    #200us;
    err_count++;
    stop_test;
  end
  initial
  begin
    {rst_n, io_wr, io_rd, card_dma_request, xfer_16bit, channel_reset, go, slow} = 8'h00;
    {io_addr, io_wdata, beats} = 20'h00000;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    rd(4'h2, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    chk({15'h0000, ctrl_disabled}, 16'h0000);
    rd(4'h3, 8'h00);
    wr(4'h2, 8'ha5);
    rd(4'h2, 8'ha5);
    wr(4'h4, 8'h05);
    wr(4'h5, 8'h00);
    rd(4'h4, 8'h05);
    xf(8'h04, 1'b0);
    chk(count_remaining, 16'h0001);
    rd(4'h8, 8'h00);
    xf(8'h01, 1'b1);
    rd(4'h8, 8'h0f);
    rd(4'h8, 8'h00);
    wr(4'h4, 8'h07);
    xfer_16bit = 1'b1;
    xf(8'h02, 1'b1);
    rd(4'h4, 8'h03);
    xf(8'h02, 1'b0);
    chk(count_remaining, 16'h0000);
    rd(4'h8, 8'h0f);
    card_dma_request = 1'b1;
    rd(4'h8, 8'hf0);
    card_dma_request = 1'b0;
    rd(4'h8, 8'h00);
    xfer_16bit = 1'b0;
    wr(4'h4, 8'h03);
    wr(4'h8, 8'hff);
    chk({15'h0000, ctrl_disabled}, 16'h0001);
    rd(4'h8, 8'h00);
    xf(8'h02, 1'b0);
    chk(count_remaining, 16'h0003);
    wr(4'h8, 8'h00);
    chk({15'h0000, ctrl_disabled}, 16'h0000);
    xf(8'h03, 1'b0);
    @(negedge ref_clk);
    channel_reset = 1'b1;
    @(negedge ref_clk);
    channel_reset = 1'b0;
    rd(4'h8, 8'h00);
    rd(4'h2, 8'h00);
    stop_test;
  end
endmodule : dsc_channel_regs_tb
bind dsc_channel_regs dsc_channel_regs_props props_u (.ref_clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata,
  .io_rdata, .io_rvalid, .card_dma_request, .xfer_16bit, .xfer_done, .channel_reset, .addr_phase, .ad_hi_out,
  .ad_hi_oe, .ctrl_disabled, .request_status, .terminal_count, .count_remaining);
